// ===== core/ledkey_pkg.sv
// Shared constants, encodings and helper functions of the LED and key serial link
// Overview of operation
// RULE1 - Top two bits of first byte classify command
// RULE2 - Data command: write/read select, auto or fixed
// RULE3 - Frame select rising aborts the partial byte
// RULE4 - Address low nibble picks location, defaults first
// RULE5 - Even byte bits drive digit anode lines
// RULE6 - Eight scan lines by two returns, sixteen keys
// RULE7 - Read command returns four key bytes, LSB first
// RULE8 - Pressed key reads one, released reads zero
// RULE9 - Key byte layout of scan lines and returns
// RULE10 - Host reads at most four key bytes
// RULE11 - Key bytes come strictly in order
// RULE12 - Device scans keys alone once per display cycle
// RULE13 - Later key within one cycle reports first key
// RULE14 - Scan lines share pins with anode driving
// RULE15 - Host waits two microseconds before reading
// RULE16 - Auto increment: address then up to sixteen bytes
// RULE17 - Display control sent in its own frame
// RULE18 - Fixed mode: one byte per address command
// RULE19 - Key read frame: command then four bytes
package ledkey_pkg;
  // Command classes in bits 7:6
  localparam logic [1:0] CMD_DATA = 2'h1;
  localparam logic [1:0] CMD_CTRL = 2'h2;
  localparam logic [1:0] CMD_ADDR = 2'h3;
  // Data command transfer select in bits 1:0
  localparam logic [1:0] DATA_READ = 2'h2;
  // Bit positions in command bytes
  localparam int FIXED_BIT = 2;
  localparam int ON_BIT = 3;
  localparam int BRIGHT_W = 3;
  localparam int ADDR_W = 4;
  // Sizes of the display and key matrix
  localparam int LOCS = 16;
  localparam int SEG_W = 14;
  localparam int GRID_W = 8;
  localparam int SCAN_LINES = 8;
  localparam int KEY_W = 16;
  localparam int KEY_BYTES = 4;
  localparam int KEY_BITS = 32;
  localparam int SLOTS = 16;
  localparam int PULSE_DEN = 16;
  localparam logic [GRID_W-1:0] LINE0 = 8'h01;
  // Key byte bit positions, low and high nibble
  localparam int KEY_R1_LO = 2;
  localparam int KEY_R0_LO = 3;
  localparam int KEY_R1_HI = 6;
  localparam int KEY_R0_HI = 7;
  // Timing, each figure in its own unit and as a cycle count
  localparam int CLK_PERIOD_NS = 8;
  localparam real DISPLAY_CYCLE_MS = 4.7;
  localparam int DISPLAY_CYCLE_CYC = int'(DISPLAY_CYCLE_MS * 1.0e6 / CLK_PERIOD_NS);
  localparam real READ_WAIT_US = 2.0;
  localparam int READ_WAIT_CYC = int'($ceil(READ_WAIT_US * 1.0e3 / CLK_PERIOD_NS));
  localparam int CLK_PW_NS = 500;
  localparam int CLK_PW_CYC = (CLK_PW_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam real STB_GAP_US = 1.0;
  localparam int STB_GAP_CYC = int'($ceil(STB_GAP_US * 1.0e3 / CLK_PERIOD_NS));
  localparam int TIMER_W = 9;
  // Host command port map
  localparam int HADDR_W = 4;
  localparam int HDATA_W = 16;
  localparam logic [HADDR_W-1:0] REG_SEND = 4'h0;
  localparam logic [HADDR_W-1:0] REG_STATUS = 4'h4;
  localparam logic [HADDR_W-1:0] REG_RX = 4'h8;
  localparam int SEND_FIRST = 8;
  localparam int SEND_LAST = 9;
  localparam int SEND_READ = 10;
  localparam int STAT_BUSY = 0;
  localparam int STAT_REFUSED = 1;

  // Lit time in sixteenths for each brightness level
  function automatic logic [4:0] pulse_sixteenths(input logic [BRIGHT_W-1:0] lvl);
    unique case (lvl)
      3'h0: return 5'h01;
      3'h1: return 5'h02;
      3'h2: return 5'h04;
      3'h3: return 5'h0a;
      3'h4: return 5'h0b;
      3'h5: return 5'h0c;
      3'h6: return 5'h0d;
      3'h7: return 5'h0e;
    endcase
  endfunction

  // Scatter line pairs {return1, return0} into the four key bytes
  function automatic logic [KEY_BITS-1:0] key_vector(input logic [KEY_W-1:0] keys);
    logic [KEY_BITS-1:0] v;
    v = '0;
    for (int n = 0; n < KEY_BYTES; n++)
    begin
      v[8*n+KEY_R1_LO] = keys[4*n+1];
      v[8*n+KEY_R0_LO] = keys[4*n];
      v[8*n+KEY_R1_HI] = keys[4*n+3];
      v[8*n+KEY_R0_HI] = keys[4*n+2];
    end
    return v;
  endfunction
endpackage

// ===== core/ledkey_if.sv
// Three-wire serial link between host and LED driver, open-drain data line
`timescale 1ns/100ps
`default_nettype none
interface ledkey_if;
  logic serial_clk; // Driven by host, idle high
  logic frame_select; // Driven by host, low during a frame
  logic dio_host_out; // Host data value
  logic dio_host_oe; // Host drives the data line
  logic dio_dev_out; // Device data value
  logic dio_dev_oe; // Device drives the data line
  logic dio; // Resolved line, pulled up when nobody pulls low

  // Open drain: any enabled low value pulls the line down
  assign dio = !((dio_host_oe && !dio_host_out) || (dio_dev_oe && !dio_dev_out));

  modport device(input serial_clk, input frame_select, input dio,
    output dio_dev_out, output dio_dev_oe);
  modport host(output serial_clk, output frame_select, output dio_host_out,
    output dio_host_oe, input dio);
endinterface
`default_nettype wire

// ===== core/ledkey_device.sv
// LED driver end: serial command decode, display memory, multiplexing and key scan
`timescale 1ns/100ps
`default_nettype none
module ledkey_device #(
  parameter int CYCLE_CYC = ledkey_pkg::DISPLAY_CYCLE_CYC
) (
  ledkey_if.device link,
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic return_input_zero_in,
  input wire logic return_input_one_in,
  output logic [ledkey_pkg::SEG_W-1:0] anode_drive_line_out,
  output logic [ledkey_pkg::GRID_W-1:0] cathode_drive_line_out
);
  import ledkey_pkg::*;

  localparam int SLOT_CYC = CYCLE_CYC / SLOTS;
  localparam int SC_W = $clog2(SLOT_CYC + 1);

  typedef enum logic [1:0] {L_CMD, L_DATA, L_READ, L_IGNORE} link_state_t;

  // ---- Link domain, clocked by the host's serial clock ----
  logic link_rst_n; // Frame select high holds the shifter in reset
  link_state_t state; // Position within the frame
  link_state_t next_after_cmd; // State chosen by the command byte
  logic [2:0] bit_cnt; // Bits received of the current byte
  logic [6:0] shift; // Bits already received, LSB first
  logic [7:0] rx_byte; // Byte completed on this edge
  logic byte_done; // Eighth rising edge of a byte
  logic [ADDR_W-1:0] addr_ptr; // Display write pointer
  logic addr_ok; // Pointer inside the valid range
  logic fixed_mode; // Fixed address mode
  logic xfer_ctrl; // Held transfer is a display control byte
  logic [ADDR_W-1:0] xfer_addr; // Held transfer address
  logic [7:0] xfer_byte; // Held transfer data
  logic xfer_tgl; // Flips once per held transfer
  logic [5:0] out_idx; // Key bits already sent
  logic drive_low; // Pull the data line low
  logic [KEY_BITS-1:0] key_vec; // Key bytes as sent

  // Frame select high discards a partial byte but keeps settings
  assign link_rst_n = nrst_in && !link.frame_select; // see RULE3
  assign rx_byte = {link.dio, shift};
  assign byte_done = (bit_cnt == 3'h7);

  // Shift data in on rising edges, LSB first
  always_ff @(posedge link.serial_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      bit_cnt <= '0; // see RULE3
      shift <= '0;
    end
    else
    begin
      bit_cnt <= bit_cnt + 3'h1;
      shift <= rx_byte[7:1];
    end
  end

  // Classify the first byte of a frame
  always_comb
  begin
    next_after_cmd = L_IGNORE;
    if (rx_byte[7:6] == CMD_ADDR)
      next_after_cmd = L_DATA; // see RULE1
    else if (rx_byte[7:6] == CMD_DATA && rx_byte[1:0] == DATA_READ)
      next_after_cmd = L_READ; // see RULE2
  end

  // Frame state machine
  always_ff @(posedge link.serial_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
      state <= L_CMD;
    else if (byte_done)
    begin
      unique case (state)
        L_CMD: state <= next_after_cmd; // see RULE1
        // Fixed mode takes one data byte per address
        L_DATA: state <= fixed_mode ? L_IGNORE : L_DATA; // see RULE18
        L_READ: state <= L_READ;
        L_IGNORE: state <= L_IGNORE;
      endcase
    end
  end

  // Address pointer and addressing mode, kept across frames
  always_ff @(posedge link.serial_clk or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      addr_ptr <= '0; // see RULE4
      addr_ok <= 1'b1;
      fixed_mode <= 1'b0;
    end
    else if (byte_done && state == L_CMD)
    begin
      if (rx_byte[7:6] == CMD_DATA)
        fixed_mode <= rx_byte[FIXED_BIT]; // see RULE2
      else if (rx_byte[7:6] == CMD_ADDR)
      begin
        addr_ptr <= rx_byte[ADDR_W-1:0]; // see RULE4
        addr_ok <= (rx_byte[5:4] == 2'h0);
      end
    end
    else if (byte_done && state == L_DATA && !fixed_mode)
    begin
      // Advance after each byte; past the last location the pointer wraps and writes stop
      addr_ptr <= addr_ptr + 4'h1; // see RULE16
      addr_ok <= addr_ok && (addr_ptr != 4'hf);
    end
  end

  // Hold each display byte or control byte for the core domain
  always_ff @(posedge link.serial_clk or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      xfer_ctrl <= 1'b0;
      xfer_addr <= '0;
      xfer_byte <= '0;
      xfer_tgl <= 1'b0;
    end
    else if (byte_done && state == L_CMD && rx_byte[7:6] == CMD_CTRL)
    begin
      xfer_ctrl <= 1'b1;
      xfer_byte <= rx_byte;
      xfer_tgl <= !xfer_tgl;
    end
    else if (byte_done && state == L_DATA && addr_ok)
    begin
      xfer_ctrl <= 1'b0; // see RULE16
      xfer_addr <= addr_ptr;
      xfer_byte <= rx_byte;
      xfer_tgl <= !xfer_tgl;
    end
  end

  // Key bits leave on falling edges, bytes one to four in order
  always_ff @(negedge link.serial_clk or negedge link_rst_n)
  begin
    if (!link_rst_n)
    begin
      out_idx <= '0;
      drive_low <= 1'b0;
    end
    else if (state == L_READ && out_idx < 6'(KEY_BITS))
    begin
      drive_low <= !key_vec[out_idx[4:0]]; // see RULE7
      out_idx <= out_idx + 6'h01; // see RULE11
    end
    else
      drive_low <= 1'b0;
  end

  assign link.dio_dev_out = 1'b0;
  assign link.dio_dev_oe = drive_low;

  // ---- Core domain, clocked by the internal oscillator ----
  logic [3:0] s1; // First synchroniser stage
  logic [3:0] s2; // Second stage
  logic [3:0] s3; // Third stage
  logic [3:0] settled; // Value once stages two and three agree
  logic tgl_seen; // Last transfer toggle acted upon
  logic wr_event; // A held transfer is new
  logic [7:0] mem [LOCS]; // Display memory
  logic disp_on; // Display enabled
  logic [BRIGHT_W-1:0] bright; // Brightness level
  logic [SC_W-1:0] slot_cnt; // Cycles into the current slot
  logic [3:0] slot; // Slots 0-7 digits, 8-15 key lines
  logic slot_end; // Last cycle of a slot
  logic lit; // Within the lit part of a digit slot
  logic [KEY_W-1:0] acc; // Keys gathered this cycle
  logic [KEY_W-1:0] next_keys; // Gathered keys including this line
  logic [KEY_W-1:0] key_latch; // Keys of the last full cycle
  logic [KEY_W-1:0] key_hold; // Snapshot seen by the link

  // Three-stage synchronisers for pins and the transfer toggle
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s1 <= 4'h8; // Idle levels: frame select high, returns low, toggle low
      s2 <= 4'h8;
      s3 <= 4'h8;
      settled <= 4'h8;
    end
    else
    begin
      s1 <= {link.frame_select, return_input_one_in, return_input_zero_in, xfer_tgl};
      s2 <= s1;
      s3 <= s2;
      for (int i = 0; i < 4; i++)
        if (s2[i] == s3[i])
          settled[i] <= s3[i];
    end
  end

  assign wr_event = (settled[0] != tgl_seen);

  // Acknowledge each held transfer once
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      tgl_seen <= 1'b0;
    else
      tgl_seen <= settled[0];
  end

  // Display control settings
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      disp_on <= 1'b0;
      bright <= '0;
    end
    else if (wr_event && xfer_ctrl)
    begin
      disp_on <= xfer_byte[ON_BIT];
      bright <= xfer_byte[BRIGHT_W-1:0];
    end
  end

  // Display memory writes
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      for (int i = 0; i < LOCS; i++)
        mem[i] <= '0;
    end
    else if (wr_event && !xfer_ctrl)
      mem[xfer_addr] <= xfer_byte;
  end

  assign slot_end = (slot_cnt == SC_W'(SLOT_CYC - 1));

  // Free-running display cycle, one key scan per cycle
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      slot_cnt <= '0;
      slot <= '0;
    end
    else if (slot_end)
    begin
      slot_cnt <= '0;
      slot <= slot + 4'h1; // see RULE12
    end
    else
      slot_cnt <= slot_cnt + SC_W'(1);
  end

  assign lit = (int'(slot_cnt) * PULSE_DEN) < (SLOT_CYC * int'(pulse_sixteenths(bright)));

  // Drive digits, then strobe scan lines on the shared anode pins
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      anode_drive_line_out <= '0;
      cathode_drive_line_out <= '1;
    end
    else if (!slot[3] && disp_on && lit)
    begin
      anode_drive_line_out <= {mem[{slot[2:0], 1'b1}][5:0], mem[{slot[2:0], 1'b0}]}; // see RULE5
      cathode_drive_line_out <= ~(LINE0 << slot[2:0]);
    end
    else if (!slot[3])
    begin
      anode_drive_line_out <= '0;
      cathode_drive_line_out <= '1;
    end
    else
    begin
      anode_drive_line_out <= {6'h00, LINE0 << slot[2:0]}; // see RULE14
      cathode_drive_line_out <= '1;
    end
  end

  // Current line's returns merged into the gathered keys
  always_comb
  begin
    next_keys = acc;
    next_keys[{slot[2:0], 1'b0} +: 2] = settled[2:1]; // see RULE8
  end

  // Sample returns at the end of each scan slot
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      acc <= '0;
    else if (slot[3] && slot_end)
      acc <= next_keys; // see RULE6
  end

  // Latch once per cycle; keys still held mask ones added later
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      key_latch <= '0;
    else if (slot == 4'hf && slot_end)
    begin
      if ((next_keys & key_latch) != '0)
        key_latch <= next_keys & key_latch; // see RULE13
      else
        key_latch <= next_keys;
    end
  end

  // Snapshot changes only between frames, so the link sees it steady
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      key_hold <= '0;
    else if (settled[3])
      key_hold <= key_latch;
  end

  assign key_vec = key_vector(key_hold); // see RULE9
endmodule // ledkey_device
`default_nettype wire

// ===== core/ledkey_host.sv
// Host end: turns command-port writes into framed serial bytes and reads key bytes
`timescale 1ns/100ps
`default_nettype none
module ledkey_host (
  ledkey_if.host link,
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [ledkey_pkg::HADDR_W-1:0] adr_in,
  input wire logic [ledkey_pkg::HDATA_W-1:0] wdata_in,
  input wire logic wr_in,
  input wire logic rd_in,
  output logic [ledkey_pkg::HDATA_W-1:0] rdata_out
);
  import ledkey_pkg::*;

  typedef enum logic [2:0] {H_IDLE, H_OPEN, H_WAIT, H_LOW, H_HIGH, H_CLOSE, H_GAP} host_state_t;

  host_state_t state; // Transfer sequencer
  logic [TIMER_W-1:0] cnt; // Cycles left in this phase
  logic [2:0] bit_idx; // Bit being transferred
  logic [7:0] tx; // Byte to send
  logic [7:0] rx; // Byte received
  logic is_read; // Current byte is a key read
  logic is_last; // Close the frame after this byte
  logic [2:0] reads; // Key bytes read in this frame
  logic refused; // Last send request was refused
  logic go; // Send request accepted
  logic tdone; // Phase time over
  logic s1, s2, s3; // Data line synchroniser stages
  logic din; // Settled data line

  // A fifth key read in one frame is refused
  assign go = wr_in && adr_in == REG_SEND && state == H_IDLE
    && !(wdata_in[SEND_READ] && reads == 3'(KEY_BYTES)); // see RULE10
  assign tdone = (cnt == '0);
  assign link.dio_host_out = 1'b0;

  // Data line synchroniser
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      s1 <= 1'b1;
      s2 <= 1'b1;
      s3 <= 1'b1;
      din <= 1'b1;
    end
    else
    begin
      s1 <= link.dio;
      s2 <= s1;
      s3 <= s2;
      if (s2 == s3)
        din <= s3;
    end
  end

  // Sequencer driving clock, frame select and data
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      state <= H_IDLE;
      cnt <= '0;
      bit_idx <= '0;
      tx <= '0;
      is_read <= 1'b0;
      is_last <= 1'b0;
      link.serial_clk <= 1'b1;
      link.frame_select <= 1'b1;
      link.dio_host_oe <= 1'b0;
    end
    else
    begin
      if (!tdone)
        cnt <= cnt - TIMER_W'(1);
      unique case (state)
        H_IDLE:
          if (go)
          begin
            tx <= wdata_in[7:0];
            is_read <= wdata_in[SEND_READ];
            is_last <= wdata_in[SEND_LAST];
            bit_idx <= '0;
            // A first byte opens a frame; reads wait for the device
            if (wdata_in[SEND_FIRST])
            begin
              link.frame_select <= 1'b0; // see RULE19
              state <= H_OPEN;
              cnt <= TIMER_W'(CLK_PW_CYC);
            end
            else if (wdata_in[SEND_READ])
            begin
              state <= H_WAIT;
              cnt <= TIMER_W'(READ_WAIT_CYC); // see RULE15
            end
            else
            begin
              state <= H_WAIT;
              cnt <= '0;
            end
          end
        H_OPEN, H_WAIT:
          if (tdone)
          begin
            link.serial_clk <= 1'b0;
            link.dio_host_oe <= !is_read && !tx[0];
            state <= H_LOW;
            cnt <= TIMER_W'(CLK_PW_CYC);
          end
        H_LOW:
          if (tdone)
          begin
            link.serial_clk <= 1'b1;
            state <= H_HIGH;
            cnt <= TIMER_W'(CLK_PW_CYC);
          end
        H_HIGH:
          if (tdone && bit_idx == 3'h7)
          begin
            link.dio_host_oe <= 1'b0;
            state <= is_last ? H_CLOSE : H_IDLE;
            cnt <= TIMER_W'(STB_GAP_CYC);
          end
          else if (tdone)
          begin
            bit_idx <= bit_idx + 3'h1;
            link.serial_clk <= 1'b0;
            link.dio_host_oe <= !is_read && !tx[bit_idx + 3'h1];
            state <= H_LOW;
            cnt <= TIMER_W'(CLK_PW_CYC);
          end
        H_CLOSE:
          if (tdone)
          begin
            // Each frame ends here, so control goes in a frame of its own
            link.frame_select <= 1'b1; // see RULE17
            state <= H_GAP;
            cnt <= TIMER_W'(STB_GAP_CYC);
          end
        H_GAP:
          if (tdone)
            state <= H_IDLE;
      endcase
    end
  end

  // Capture read bits at the end of each clock high phase, LSB first
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rx <= '0;
    else if (state == H_HIGH && tdone && is_read)
      rx <= {din, rx[7:1]}; // see RULE11
  end

  // Count key reads per frame and note refusals
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      reads <= '0;
      refused <= 1'b0;
    end
    else
    begin
      if (wr_in && adr_in == REG_SEND)
        refused <= !go;
      if (go && wdata_in[SEND_FIRST])
        reads <= '0;
      else if (go && wdata_in[SEND_READ])
        reads <= reads + 3'h1; // see RULE10
    end
  end

  // Register reads answer one cycle later
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rdata_out <= '0;
    else if (rd_in && adr_in == REG_STATUS)
    begin
      rdata_out <= '0;
      rdata_out[STAT_BUSY] <= (state != H_IDLE);
      rdata_out[STAT_REFUSED] <= refused;
    end
    else if (rd_in && adr_in == REG_RX)
      rdata_out <= {8'h00, rx};
    else
      rdata_out <= '0;
  end
endmodule // ledkey_host
`default_nettype wire

// ===== bench/ledkey_props.sv
// Concurrent checks on the host to driver serial link
`timescale 1ns/100ps
`default_nettype none
module ledkey_props (
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic serial_clk,
  input wire logic frame_select,
  input wire logic dio_host_out,
  input wire logic dio_host_oe,
  input wire logic dio_dev_out,
  input wire logic dio_dev_oe,
  input wire logic dio
);
  logic [8:0] hi_run; // Cycles the serial clock has been high

  // Length of the current high phase, saturating
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      hi_run <= '0;
    else if (!serial_clk)
      hi_run <= '0;
    else if (hi_run != 9'h1ff)
      hi_run <= hi_run + 9'h001;
  end

  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);

  a_dev_open_drain: assert property (dio_dev_out == 1'b0)
    else $error("device drove data line high");
  a_no_contention: assert property (!(dio_host_oe && dio_dev_oe))
    else $error("both ends drive data line");
  a_dev_release: assert property (frame_select [*2] |-> !dio_dev_oe)
    else $error("device drives outside a frame");
  a_clk_idle_high: assert property (frame_select |-> serial_clk)
    else $error("serial clock low outside a frame");
  a_dev_on_fall: assert property (!frame_select && $changed(dio_dev_oe) |-> $fell(serial_clk))
    else $error("device data changed off a falling edge");
  a_host_bit_setup: assert property ($rose(serial_clk) |-> $stable(dio_host_oe))
    else $error("host data moved at rising edge");
  a_clk_high_width: assert property ($fell(serial_clk) |-> hi_run >= 9'd62)
    else $error("serial clock high phase too short");
  a_frame_end_gap: assert property ($rose(frame_select) |-> hi_run >= 9'd125)
    else $error("frame closed too soon after clock");

  cover property ($rose(frame_select));
  cover property (dio_dev_oe && !dio);
  cover property (!frame_select && $fell(serial_clk));
endmodule // ledkey_props
`default_nettype wire

// ===== bench/led_driver_serial_keyscan_test.sv
// Self-checking bench joining host and driver ends over the serial link
`timescale 1ns/100ps
`default_nettype none
module led_driver_serial_keyscan_test;
  import ledkey_pkg::*;
  localparam int CYC = 320; // Short display cycle
  logic clk_in; // System clock
  logic nrst_in; // Reset, active low
  logic [HADDR_W-1:0] adr; // Port address
  logic [HDATA_W-1:0] wdata; // Port write data
  logic wr_s, rd_s; // Write and read strobes
  logic [HDATA_W-1:0] rdata; // Port read data
  logic [SEG_W-1:0] anode; // Anode lines
  logic [GRID_W-1:0] cath; // Cathode lines, active low
  logic [7:0] press0, press1; // Keys on return zero and one, bit per scan line
  logic ret0, ret1; // Returns zero and one from the matrix
  logic [7:0] mem [LOCS]; // Expected display memory
  logic mon_on; // Display monitor enabled
  int mismatches = 0;
  int total_checks = 0;
  int seed;

  // Key matrix: a held key joins its strobe to its return
  assign ret0 = |(anode[7:0] & press0);
  assign ret1 = |(anode[7:0] & press1);

  ledkey_if u_ledkey_if ();
  ledkey_host u_ledkey_host (.link(u_ledkey_if), .clk_in(clk_in), .nrst_in(nrst_in),
    .adr_in(adr), .wdata_in(wdata), .wr_in(wr_s), .rd_in(rd_s), .rdata_out(rdata));
  ledkey_device #(.CYCLE_CYC(CYC)) u_ledkey_device (.link(u_ledkey_if), .clk_in(clk_in),
    .nrst_in(nrst_in), .return_input_zero_in(ret0), .return_input_one_in(ret1),
    .anode_drive_line_out(anode), .cathode_drive_line_out(cath));
  ledkey_props u_ledkey_props (.clk_in(clk_in), .nrst_in(nrst_in),
    .serial_clk(u_ledkey_if.serial_clk), .frame_select(u_ledkey_if.frame_select),
    .dio_host_out(u_ledkey_if.dio_host_out), .dio_host_oe(u_ledkey_if.dio_host_oe),
    .dio_dev_out(u_ledkey_if.dio_dev_out), .dio_dev_oe(u_ledkey_if.dio_dev_oe),
    .dio(u_ledkey_if.dio));

  // Clock at 8 ns
  initial
  begin
    clk_in = 1'b0;
    forever #4 clk_in = ~clk_in;
  end

  // Count and report one comparison
  task automatic note(input logic ok, input logic [15:0] g, input logic [15:0] e);
    total_checks++;
    if (!ok)
    begin
      mismatches++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask
  task automatic chk_flag(input logic g, input logic e);
    note(g === e, {15'h0000, g}, {15'h0000, e});
  endtask
  task automatic chk_key(input logic [7:0] g, input logic [7:0] e);
    note(g === e, {8'h00, g}, {8'h00, e});
  endtask
  task automatic chk_seg(input logic [SEG_W-1:0] g, input logic [SEG_W-1:0] e);
    note(g === e, {2'h0, g}, {2'h0, e});
  endtask

  // Port cycles: one-cycle strobes launched after a rising edge
  task automatic wr(input logic [HADDR_W-1:0] a, input logic [HDATA_W-1:0] d);
    @(posedge clk_in);
    adr <= a;
    wdata <= d;
    wr_s <= 1'b1;
    @(posedge clk_in);
    wr_s <= 1'b0;
  endtask
  task automatic rd(input logic [HADDR_W-1:0] a, output logic [HDATA_W-1:0] d);
    @(posedge clk_in);
    adr <= a;
    rd_s <= 1'b1;
    @(posedge clk_in);
    rd_s <= 1'b0;
    @(negedge clk_in);
    d = rdata;
  endtask

  // Poll busy under a bound, then hand over one byte with its flags
  task automatic wait_idle();
    logic [HDATA_W-1:0] s;
    s = '1;
    for (int i = 0; i < 3000 && s[STAT_BUSY] !== 1'b0; i++)
      rd(REG_STATUS, s);
    if (s[STAT_BUSY] !== 1'b0) mismatches++; // Poll limit ran out
  endtask
  task automatic send(input logic [7:0] b, input logic [2:0] f);
    wait_idle();
    wr(REG_SEND, {5'h00, f, b});
  endtask

  // Expected key stream from the held keys
  function automatic logic [31:0] key_exp(input logic [7:0] p0, input logic [7:0] p1);
    logic [31:0] v;
    v = '0;
    for (int n = 0; n < 4; n++)
    begin
      v[8*n+3] = p0[2*n];
      v[8*n+2] = p1[2*n];
      v[8*n+7] = p0[2*n+1];
      v[8*n+6] = p1[2*n+1];
    end
    return v;
  endfunction

  // One read frame: command, then four key bytes in order
  task automatic read_keys(input logic [31:0] e);
    logic [HDATA_W-1:0] r;
    send(8'h42, 3'h1);
    for (int n = 0; n < KEY_BYTES; n++)
    begin
      send(8'h00, {1'b1, n == 3, 1'b0});
      wait_idle();
      rd(REG_RX, r);
      chk_key(r[7:0] & 8'hcc, e[8*n+:8]);
    end
  endtask

  // Watch the display for two cycles
  task automatic check_disp();
    wait_idle();
    mon_on <= 1'b1;
    repeat (2 * CYC) @(posedge clk_in);
    mon_on <= 1'b0;
  endtask

  // Change keys while a digit is lit, so no scan sees half a set, then wait two cycles
  task automatic hold(input logic [7:0] p0, input logic [7:0] p1);
    do @(posedge clk_in); while (cath === 8'hff);
    press0 <= p0;
    press1 <= p1;
    repeat (2 * CYC) @(posedge clk_in);
  endtask

  // Lit digit must show its even and odd memory bytes
  always @(negedge clk_in)
  begin
    if (mon_on)
    begin
      for (int d = 0; d < GRID_W; d++)
      begin
        if (cath === ~(LINE0 << d))
          chk_seg(anode, {mem[2*d+1][5:0], mem[2*d]});
      end
    end
  end

  task automatic end_sim();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask

  // Hang guard
  initial
  begin
    repeat (90000) @(posedge clk_in);
    mismatches++;
    end_sim();
  end

  // Main sequence
  initial
  begin
    logic [HDATA_W-1:0] r;
    logic [3:0] a;
    logic [7:0] b;
    seed = 32'h95a5d95d;
    nrst_in <= 1'b0;
    adr <= '0;
    wdata <= '0;
    wr_s <= 1'b0;
    rd_s <= 1'b0;
    mon_on <= 1'b0;
    press0 <= 8'h00;
    press1 <= 8'h00;
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (8) @(posedge clk_in);
    // Control frame, then a send while busy and a write to an unmapped place
    wr(REG_SEND, 16'h038f);
    wr(REG_SEND, 16'h0340);
    rd(REG_STATUS, r);
    chk_flag(r[STAT_REFUSED], 1'b1);
    wait_idle();
    wr(4'hc, 16'h0340);
    rd(REG_STATUS, r);
    chk_flag(r[STAT_BUSY], 1'b0);
    // Auto increment over all sixteen places
    for (int i = 0; i < LOCS; i++)
      mem[i] = 8'($random(seed));
    send(8'h40, 3'h3);
    send(8'hc0, 3'h1);
    for (int i = 0; i < LOCS; i++)
      send(mem[i], {1'b0, i == 15, 1'b0});
    send(8'h8f, 3'h3);
    check_disp();
    // Fixed address: the extra byte and the invalid place are dropped
    send(8'h44, 3'h3);
    for (int k = 0; k < 3; k++)
    begin
      a = 4'($random(seed));
      b = 8'($random(seed));
      mem[a] = b;
      send({4'hc, a}, 3'h1);
      send(b, 3'h0);
      send(~b, 3'h2);
    end
    send(8'hd0, 3'h1);
    send(8'h5a, 3'h2);
    check_disp();
    // Random key sets pressed together
    for (int k = 0; k < 2; k++)
    begin
      hold(8'h00, 8'h00);
      b = 8'($random(seed));
      a = 4'($random(seed));
      hold(b, {a, ~a});
      read_keys(key_exp(b, {a, ~a}));
    end
    // First key held wins over a later one
    hold(8'h00, 8'h00);
    hold(8'h01, 8'h00);
    hold(8'h01, 8'h80);
    read_keys(key_exp(8'h01, 8'h00));
    read_keys(key_exp(8'h01, 8'h00));
    // A fifth key read after four in the frame is refused
    send(8'h00, 3'h4);
    rd(REG_STATUS, r);
    chk_flag(r[STAT_REFUSED], 1'b1);
    end_sim();
  end
endmodule // led_driver_serial_keyscan_test
`default_nettype wire
